/* File: pkg/ufb_consts.svh */
/*
 * Constants of the serial block: indices,
 * field positions, reset values, bit times.
 * Assumes inclusion by bare name.
 */
`ifndef UFB_CONSTS_SVH
`define UFB_CONSTS_SVH

`define UFB_NUM_CH      2
`define UFB_CH_BIT      5
`define UFB_MAP_TOP     6
`define UFB_IDX_DATA    3'h0
`define UFB_IDX_IEN     3'h1
`define UFB_IDX_IDN     3'h2
`define UFB_IDX_FMT     3'h3
`define UFB_IDX_MCT     3'h4
`define UFB_IDX_LST     3'h5
`define UFB_IDX_MST     3'h6
`define UFB_IDX_SCR     3'h7
`define UFB_FMT_STP     2
`define UFB_FMT_PAR     3
`define UFB_FMT_EVN     4
`define UFB_FMT_STICK   5
`define UFB_FMT_BRK     6
`define UFB_FMT_LAT     7
`define UFB_MCT_DTR     0
`define UFB_MCT_RTS     1
`define UFB_MCT_OUT1    2
`define UFB_MCT_OUT2    3
`define UFB_IEN_MASK    8'h0F
`define UFB_MCT_MASK    8'h1F
`define UFB_ALT_MASK    8'h07
`define UFB_IDN_NONE    8'h01
`define UFB_LEN_BASE    3'h4
`define UFB_BIT_LAST    5'h0F
`define UFB_STOP15_LAST 5'h17
`define UFB_STOP2_LAST  5'h1F
`define UFB_RX_MID      4'h7
`define UFB_RX_LAST     4'hF
`define UFB_TICK_AT     16'h0001

`endif

/* File: pkg/ufb_pkg.sv */
/*
 * Types of the serial block: state
 * enums, channel and block state.
 * Assumes ufb_consts.svh on the include path.
 */
`default_nettype none

`include "ufb_consts.svh"

package ufb_pkg;

    typedef enum logic [2:0] {
        tx_idle, tx_start, tx_data, tx_par, tx_stop
    } ufb_tx_st_t;

    typedef enum logic [2:0] {
        rx_idle, rx_start, rx_data, rx_par, rx_stop, rx_brk
    } ufb_rx_st_t;

    typedef struct packed {
        logic [7:0]  fmt;
        logic [7:0]  ien;
        logic [7:0]  fcr;
        logic [7:0]  mct;
        logic [7:0]  alt;
        logic [7:0]  scr;
        logic [7:0]  dvl;
        logic [7:0]  dvh;
        logic [15:0] baud_cnt;
        logic [7:0]  hld;
        logic        hld_full;
        logic [7:0]  shf;
        ufb_tx_st_t  tx_st;
        logic [4:0]  tx_cnt;
        logic [2:0]  tx_bit;
        logic        tx_space;
        logic [7:0]  rbr;
        logic [7:0]  rx_sh;
        logic        dr;
        logic        oe;
        logic        pe;
        logic        fe;
        logic        bi;
        ufb_rx_st_t  rx_st;
        logic [3:0]  rx_cnt;
        logic [2:0]  rx_bit;
        logic        rx_perr;
        logic        rx_zero;
        logic [3:0]  mst_dlt;
        logic [3:0]  mst_prev;
        logic        mst_primed;
    } ufb_chan_t;

    typedef struct packed {
        ufb_chan_t [`UFB_NUM_CH-1:0] ch;
        logic                        wr_pend;
        logic [7:0]                  wr_addr;
        logic [7:0]                  rdata;
    } ufb_state_t;

endpackage

`default_nettype wire

/* File: logic/ufb_top.sv */
/*
 * Dual serial channel behind an AHB-Lite slave.
 * Format, baud, transmit, receive, modem status.
 * Assumes one 125 MHz ref_clk, synchronous inputs.
 * Assumes one master, whole-word single transfers.
 */
// Contract
// R1 - each channel has its own register set
// R2 - format register reads back last write
// R3 - low two format bits pick 5 to 8 data bits
// R4 - stop select zero: one stop bit
// R5 - stop select one, five bits: 1.5 stop bits
// R6 - stop select one, longer: two stop bits
// R7 - receiver checks only the first stop bit
// R8 - enabled parity bit follows last data bit
// R9 - sense zero odd parity, one even
// R10 - fixed parity sends inverse of sense
// R11 - break holds output low; shifter runs on
// R12 - software clears break once tx empty
// R13 - latch bit steers to divisor, alternate
// R14 - baud divisor 1 to 65535
// R15 - 16x tick clocks own tx and rx
// R16 - divisor: low and high byte latches
// R17 - divisor byte write reloads counter
// R18 - software loads divisor before use
// R19 - software never writes divisor zero
// R20 - reset clears modem change flags
// R21 - empty flag: holding and shift empty
// R22 - reset: status 0x60, ident 0x01, out high
// R23 - reset: modem outputs high, no data
`timescale 1ns/100ps
`default_nettype none

`include "ufb_consts.svh"

module ufb_top (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic [`UFB_NUM_CH-1:0] serial_in,
    output logic [`UFB_NUM_CH-1:0]      serial_out,
    input  wire logic [`UFB_NUM_CH-1:0] cts_n,
    input  wire logic [`UFB_NUM_CH-1:0] dsr_n,
    input  wire logic [`UFB_NUM_CH-1:0] ri_n,
    input  wire logic [`UFB_NUM_CH-1:0] dcd_n,
    output logic [`UFB_NUM_CH-1:0]      rts_n,
    output logic [`UFB_NUM_CH-1:0]      dtr_n,
    output logic [`UFB_NUM_CH-1:0]      out1_n,
    output logic [`UFB_NUM_CH-1:0]      out2_n
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic ufb_hit(input logic [31:0] a, input int c);
        ufb_hit = (a[31:`UFB_MAP_TOP] == '0) && (a[`UFB_CH_BIT] == c[0]);
    endfunction

    function automatic logic [2:0] ufb_idx(input logic [31:0] a);
        ufb_idx = a[4:2];
    endfunction

    function automatic logic [2:0] ufb_last(input logic [7:0] l);
        ufb_last = 3'(`UFB_LEN_BASE + {1'b0, l[1:0]});
    endfunction

    // parity bit for a character, masked to its length
    function automatic logic ufb_par(input logic [7:0] l,
                                     input logic [7:0] d);
        logic [7:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            m[i] = d[i] & (3'(i) <= ufb_last(l));
        end
        if (l[`UFB_FMT_STICK])
            ufb_par = ~l[`UFB_FMT_EVN]; // see R10
        else
            ufb_par = (^m) ^ ~l[`UFB_FMT_EVN]; // see R9
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_q;
    logic       rst_i_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_i_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////
    // state

    ufb_pkg::ufb_state_t s_q;
    ufb_pkg::ufb_state_t s_d;

    always_comb begin
        logic       take;
        logic       rd;
        logic       wr;
        logic [2:0] ridx;
        logic [2:0] widx;
        logic       tick;
        logic       sin;
        logic [2:0] last;
        logic [4:0] stop_last;
        logic [3:0] cur;
        logic [7:0] wd;
        take      = 1'b0;
        rd        = 1'b0;
        wr        = 1'b0;
        ridx      = '0;
        widx      = '0;
        tick      = 1'b0;
        sin       = 1'b1;
        last      = '0;
        stop_last = '0;
        cur       = '0;
        wd        = hwdata[7:0];
        s_d       = s_q;

        // zero-wait slave
        take         = hsel & htrans[1] & hready;
        s_d.wr_pend  = take & hwrite & (haddr[31:`UFB_MAP_TOP] == '0);
        s_d.wr_addr  = take ? haddr[7:0] : s_q.wr_addr;
        s_d.rdata    = 8'h00;
        ridx         = ufb_idx(haddr);
        widx         = ufb_idx({24'h0, s_q.wr_addr});

        for (int c = 0; c < `UFB_NUM_CH; c++) begin // see R1
            rd   = take & ~hwrite & ufb_hit(haddr, c);
            wr   = s_q.wr_pend & ufb_hit({24'h0, s_q.wr_addr}, c);
            sin  = serial_in[c];
            last = ufb_last(s_q.ch[c].fmt); // see R3
            cur  = {~dcd_n[c], ~ri_n[c], ~dsr_n[c], ~cts_n[c]};

            //////////////////////////////////////////////////////////
            // reads: data next cycle
            if (rd) begin
                case (ridx)
                    `UFB_IDX_DATA: begin
                        if (s_q.ch[c].fmt[`UFB_FMT_LAT]) begin // see R13
                            s_d.rdata = s_q.ch[c].dvl;
                        end else begin
                            s_d.rdata    = s_q.ch[c].rbr;
                            s_d.ch[c].dr = 1'b0;
                        end
                    end
                    `UFB_IDX_IEN: begin
                        s_d.rdata = s_q.ch[c].fmt[`UFB_FMT_LAT]
                                  ? s_q.ch[c].dvh : s_q.ch[c].ien;
                    end
                    `UFB_IDX_IDN: begin
                        s_d.rdata = s_q.ch[c].fmt[`UFB_FMT_LAT]
                                  ? s_q.ch[c].alt : `UFB_IDN_NONE;
                    end
                    `UFB_IDX_FMT: s_d.rdata = s_q.ch[c].fmt; // see R2
                    `UFB_IDX_MCT: s_d.rdata = s_q.ch[c].mct;
                    `UFB_IDX_LST: begin
                        s_d.rdata = {1'b0,
                            ~s_q.ch[c].hld_full &
                            (s_q.ch[c].tx_st == ufb_pkg::tx_idle), // see R21
                            ~s_q.ch[c].hld_full, s_q.ch[c].bi,
                            s_q.ch[c].fe, s_q.ch[c].pe, s_q.ch[c].oe,
                            s_q.ch[c].dr};
                        s_d.ch[c].oe = 1'b0;
                        s_d.ch[c].pe = 1'b0;
                        s_d.ch[c].fe = 1'b0;
                        s_d.ch[c].bi = 1'b0;
                    end
                    `UFB_IDX_MST: begin
                        s_d.rdata         = {cur, s_q.ch[c].mst_dlt};
                        s_d.ch[c].mst_dlt = 4'h0;
                    end
                    default: s_d.rdata = s_q.ch[c].scr;
                endcase
            end

            //////////////////////////////////////////////////////////
            // baud generator, 16x rate for both directions
            tick = (s_q.ch[c].baud_cnt <= `UFB_TICK_AT); // see R14
            s_d.ch[c].baud_cnt = tick
                ? {s_q.ch[c].dvh, s_q.ch[c].dvl}
                : 16'(s_q.ch[c].baud_cnt - 16'h0001);

            //////////////////////////////////////////////////////////
            // transmitter, one bit per 16 ticks
            if (s_q.ch[c].fmt[`UFB_FMT_STP] == 1'b0)
                stop_last = `UFB_BIT_LAST; // see R4
            else if (s_q.ch[c].fmt[1:0] == 2'b00)
                stop_last = `UFB_STOP15_LAST; // see R5
            else
                stop_last = `UFB_STOP2_LAST; // see R6

            if (tick) begin // see R15
                s_d.ch[c].tx_cnt = 5'(s_q.ch[c].tx_cnt + 5'h01);
                case (s_q.ch[c].tx_st)
                    ufb_pkg::tx_idle: begin
                        s_d.ch[c].tx_space = 1'b0;
                        s_d.ch[c].tx_cnt   = 5'h00;
                        if (s_q.ch[c].hld_full) begin
                            s_d.ch[c].shf      = s_q.ch[c].hld;
                            s_d.ch[c].hld_full = 1'b0;
                            s_d.ch[c].tx_st    = ufb_pkg::tx_start;
                            s_d.ch[c].tx_space = 1'b1;
                        end
                    end
                    ufb_pkg::tx_start: begin
                        if (s_q.ch[c].tx_cnt == `UFB_BIT_LAST) begin
                            s_d.ch[c].tx_cnt   = 5'h00;
                            s_d.ch[c].tx_bit   = 3'h0;
                            s_d.ch[c].tx_st    = ufb_pkg::tx_data;
                            s_d.ch[c].tx_space = ~s_q.ch[c].shf[0];
                        end
                    end
                    ufb_pkg::tx_data: begin
                        if (s_q.ch[c].tx_cnt == `UFB_BIT_LAST) begin
                            s_d.ch[c].tx_cnt = 5'h00;
                            if (s_q.ch[c].tx_bit != last) begin
                                s_d.ch[c].tx_bit   = 3'(s_q.ch[c].tx_bit + 3'h1);
                                s_d.ch[c].tx_space =
                                    ~s_q.ch[c].shf[3'(s_q.ch[c].tx_bit + 3'h1)];
                            end else if (s_q.ch[c].fmt[`UFB_FMT_PAR]) begin
                                s_d.ch[c].tx_st    = ufb_pkg::tx_par; // see R8
                                s_d.ch[c].tx_space =
                                    ~ufb_par(s_q.ch[c].fmt, s_q.ch[c].shf);
                            end else begin
                                s_d.ch[c].tx_st    = ufb_pkg::tx_stop;
                                s_d.ch[c].tx_space = 1'b0;
                            end
                        end
                    end
                    ufb_pkg::tx_par: begin
                        if (s_q.ch[c].tx_cnt == `UFB_BIT_LAST) begin
                            s_d.ch[c].tx_cnt   = 5'h00;
                            s_d.ch[c].tx_st    = ufb_pkg::tx_stop;
                            s_d.ch[c].tx_space = 1'b0;
                        end
                    end
                    ufb_pkg::tx_stop: begin
                        if (s_q.ch[c].tx_cnt == stop_last) begin
                            s_d.ch[c].tx_cnt = 5'h00;
                            s_d.ch[c].tx_st  = ufb_pkg::tx_idle;
                        end
                    end
                    default: s_d.ch[c].tx_st = ufb_pkg::tx_idle;
                endcase
            end

            //////////////////////////////////////////////////////////
            // receiver, sampling mid-bit
            if (tick) begin // see R15
                s_d.ch[c].rx_cnt = 4'(s_q.ch[c].rx_cnt + 4'h1);
                case (s_q.ch[c].rx_st)
                    ufb_pkg::rx_idle: begin
                        s_d.ch[c].rx_cnt = 4'h0;
                        if (!sin)
                            s_d.ch[c].rx_st = ufb_pkg::rx_start;
                    end
                    ufb_pkg::rx_start: begin
                        if (s_q.ch[c].rx_cnt == `UFB_RX_MID) begin
                            s_d.ch[c].rx_cnt  = 4'h0;
                            s_d.ch[c].rx_bit  = 3'h0;
                            s_d.ch[c].rx_sh   = 8'h00;
                            s_d.ch[c].rx_perr = 1'b0;
                            s_d.ch[c].rx_zero = 1'b1;
                            // a glitch shorter than half a bit is no start
                            s_d.ch[c].rx_st = sin ? ufb_pkg::rx_idle
                                                  : ufb_pkg::rx_data;
                        end
                    end
                    ufb_pkg::rx_data: begin
                        if (s_q.ch[c].rx_cnt == `UFB_RX_LAST) begin
                            s_d.ch[c].rx_sh[s_q.ch[c].rx_bit] = sin;
                            s_d.ch[c].rx_zero = s_q.ch[c].rx_zero & ~sin;
                            s_d.ch[c].rx_bit  = 3'(s_q.ch[c].rx_bit + 3'h1);
                            if (s_q.ch[c].rx_bit == last)
                                s_d.ch[c].rx_st = s_q.ch[c].fmt[`UFB_FMT_PAR]
                                    ? ufb_pkg::rx_par : ufb_pkg::rx_stop;
                        end
                    end
                    ufb_pkg::rx_par: begin
                        if (s_q.ch[c].rx_cnt == `UFB_RX_LAST) begin
                            s_d.ch[c].rx_perr = sin ^
                                ufb_par(s_q.ch[c].fmt, s_q.ch[c].rx_sh); // see R8
                            s_d.ch[c].rx_zero = s_q.ch[c].rx_zero & ~sin;
                            s_d.ch[c].rx_st   = ufb_pkg::rx_stop;
                        end
                    end
                    ufb_pkg::rx_stop: begin
                        // only the first stop bit is looked at
                        if (s_q.ch[c].rx_cnt == `UFB_RX_LAST) begin // see R7
                            s_d.ch[c].rbr = s_q.ch[c].rx_sh;
                            s_d.ch[c].dr  = 1'b1;
                            if (s_q.ch[c].dr)
                                s_d.ch[c].oe = 1'b1;
                            if (s_q.ch[c].rx_perr)
                                s_d.ch[c].pe = 1'b1;
                            if (!sin)
                                s_d.ch[c].fe = 1'b1;
                            if (!sin && s_q.ch[c].rx_zero) begin
                                s_d.ch[c].bi    = 1'b1;
                                s_d.ch[c].rx_st = ufb_pkg::rx_brk;
                            end else begin
                                s_d.ch[c].rx_st = ufb_pkg::rx_idle;
                            end
                        end
                    end
                    ufb_pkg::rx_brk: begin
                        // one zero char per break, then await mark
                        if (sin)
                            s_d.ch[c].rx_st = ufb_pkg::rx_idle;
                    end
                    default: s_d.ch[c].rx_st = ufb_pkg::rx_idle;
                endcase
            end

            //////////////////////////////////////////////////////////
            // change flags; set beats read clear
            s_d.ch[c].mst_prev   = cur;
            s_d.ch[c].mst_primed = 1'b1;
            if (s_q.ch[c].mst_primed) begin // see R20
                s_d.ch[c].mst_dlt = s_d.ch[c].mst_dlt |
                    {cur[3] ^ s_q.ch[c].mst_prev[3],
                     s_q.ch[c].mst_prev[2] & ~cur[2],
                     cur[1:0] ^ s_q.ch[c].mst_prev[1:0]};
            end

            //////////////////////////////////////////////////////////
            // writes in the data phase
            if (wr) begin
                case (widx)
                    `UFB_IDX_DATA: begin
                        if (s_q.ch[c].fmt[`UFB_FMT_LAT]) begin // see R13
                            s_d.ch[c].dvl      = wd; // see R16
                            s_d.ch[c].baud_cnt = {s_q.ch[c].dvh, wd}; // see R17
                        end else begin
                            s_d.ch[c].hld      = wd;
                            s_d.ch[c].hld_full = 1'b1;
                        end
                    end
                    `UFB_IDX_IEN: begin
                        if (s_q.ch[c].fmt[`UFB_FMT_LAT]) begin // see R13
                            s_d.ch[c].dvh      = wd; // see R16
                            s_d.ch[c].baud_cnt = {wd, s_q.ch[c].dvl}; // see R17
                        end else begin
                            s_d.ch[c].ien = wd & `UFB_IEN_MASK;
                        end
                    end
                    `UFB_IDX_IDN: begin
                        if (s_q.ch[c].fmt[`UFB_FMT_LAT])
                            s_d.ch[c].alt = wd & `UFB_ALT_MASK;
                        else
                            s_d.ch[c].fcr = wd;
                    end
                    `UFB_IDX_FMT: s_d.ch[c].fmt = wd; // see R2
                    `UFB_IDX_MCT: s_d.ch[c].mct = wd & `UFB_MCT_MASK;
                    `UFB_IDX_SCR: s_d.ch[c].scr = wd;
                    default: ;
                endcase
            end
        end
    end

    // all-zero state is the documented reset image
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n)
            s_q <= '0; // see R22 R23
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = {24'h000000, s_q.rdata};

    genvar g;
    generate
        for (g = 0; g < `UFB_NUM_CH; g++) begin : g_pin
            // break masks the pin only
            assign serial_out[g] = ~(s_q.ch[g].tx_space |
                                     s_q.ch[g].fmt[`UFB_FMT_BRK]); // see R11
            assign rts_n[g]  = ~s_q.ch[g].mct[`UFB_MCT_RTS]; // see R23
            assign dtr_n[g]  = ~s_q.ch[g].mct[`UFB_MCT_DTR];
            assign out1_n[g] = ~s_q.ch[g].mct[`UFB_MCT_OUT1];
            assign out2_n[g] = ~s_q.ch[g].mct[`UFB_MCT_OUT2];
        end
    endgenerate

endmodule // ufb_top

`default_nettype wire

/* File: dv/ufb_top_asserts.sv */
/* checker: bus answers, reset image, break.
   assumes ufb_top ports, one unpipelined master. */
`timescale 1ns/100ps
`default_nettype none
`include "ufb_consts.svh"
module ufb_top_asserts (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic [31:0]            hrdata,
    input wire logic [`UFB_NUM_CH-1:0] serial_out,
    input wire logic [`UFB_NUM_CH-1:0] rts_n,
    input wire logic [`UFB_NUM_CH-1:0] dtr_n
);
    logic            ap_v_q;
    logic            ap_w_q;
    logic [5:0]      ap_a_q;
    logic [1:0][7:0] fmt_q;
    wire  take = hsel && htrans[1] && hready;
    // shadow of format registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_v_q <= 1'b0;
            ap_w_q <= 1'b0;
            ap_a_q <= 6'h00;
            fmt_q <= '0;
        end else begin
            ap_v_q <= take && haddr[31:6] == 26'h0;
            ap_w_q <= hwrite;
            ap_a_q <= haddr[5:0];
            if (ap_v_q && ap_w_q && ap_a_q[4:2] == 3'h3)
                fmt_q[ap_a_q[5]] <= hwdata[7:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_fmt;
        take && !hwrite && haddr[31:6] == 26'h0 && haddr[4:2] == 3'h3;
    endsequence
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp set");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper");
    a_rdata_idle: assert property (!$past(take && !hwrite) |-> hrdata == 32'h0)
        else $error("hrdata without read");
    a_reset_line: assert property ($rose(rst_n) |-> (serial_out & rts_n) == 2'b11)
        else $error("line or rts low");
    a_reset_modem: assert property ($rose(rst_n) |=> (dtr_n & serial_out) == 2'b11)
        else $error("dtr or line low");
    a_fmt_readback: assert property (s_rd_fmt |=> hrdata[7:0] == fmt_q[$past(haddr[5])])
        else $error("format readback");
    a_break_low: assert property (fmt_q[0][6] && $past(fmt_q[0][6]) |-> !serial_out[0])
        else $error("break line high");
endmodule // ufb_top_asserts
bind ufb_top ufb_top_asserts ufb_top_asserts_i (.*);
`default_nettype wire

/* File: dv/ufb_far_end.sv */
/* far-end serial device: sends, samples, times frames.
   assumes idle-high lines, tasks entered after an edge. */
`timescale 1ns/100ps
`default_nettype none
module ufb_far_end (
    input wire logic  ref_clk,
    input wire logic [1:0] serial_out,
    output logic      [1:0] serial_in
);
    int cyc = 0;
    always @(posedge ref_clk) cyc <= cyc + 1;
    initial serial_in = 2'b11;
    // one stop bit
    task automatic send(input int ch, input logic [11:0] f, input int nb, bc);
        for (int k = 0; k < nb; k++) begin
            serial_in[ch] <= f[k];
            repeat (bc) @(posedge ref_clk);
        end
        serial_in[ch] <= 1'b1;
    endtask
    // mid-bit samples; start-to-start time
    task automatic watch(input int ch, nb, bc, output logic [11:0] f, output int per);
        int t0;
        f = 12'h000;
        for (t0 = 0; serial_out[ch] !== 1'b0 && t0 < 9999; t0++) @(posedge ref_clk);
        t0 = cyc;
        repeat (bc / 2) @(posedge ref_clk);
        for (int k = 0; k < nb; k++) begin
            f[k] = serial_out[ch];
            if (k < nb - 1) repeat (bc) @(posedge ref_clk);
        end
        while (serial_out[ch] !== 1'b0 && cyc - t0 < 9999) @(posedge ref_clk);
        per = cyc - t0;
    endtask
endmodule // ufb_far_end
`default_nettype wire

/* File: dv/test_uart_line_format_baud_gen.sv */
/* bench of the serial block via an AHB-Lite master.
   assumes ufb_top, far-end model, bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_uart_line_format_baud_gen;
    logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0, serial_in, serial_out, rts_n, dtr_n, out1_n, out2_n;
    logic [1:0] cts_n = 2'b11, dsr_n = 2'b11, ri_n = 2'b11, dcd_n = 2'b11;
    logic [7:0] q;
    int errors = 0, comparisons = 0;
    int fmt_m [2] = '{0, 0};
    ufb_top ufb_top_i (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_in, .serial_out,
        .cts_n, .dsr_n, .ri_n, .dcd_n, .rts_n, .dtr_n, .out1_n, .out2_n);
    ufb_far_end ufb_far_end_i (.ref_clk, .serial_out, .serial_in);
    initial forever #4 ref_clk = ~ref_clk;
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step;
        int n;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin errors++; finish_test(); end
    endtask
    task automatic bus(input logic w, input int ch, ix, d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= ch * 32 + ix * 4;
        step();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d & 255;
        step();
        q = hrdata[7:0];
    endtask
    task automatic rdc(input string what, input int ch, ix, input logic [31:0] exp);
        bus(0, ch, ix, 0);
        chk(what, exp, {24'h0, q});
    endtask
    initial begin
        int d, mask, fx, p, pn, n, nb, dv, ch, per, cfg, bad, e;
        logic [11:0] f;
        void'($urandom(32'h2409145c));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int c = 0; c < 2; c++) begin
            rdc("fmt rst", c, 3, 0);
            rdc("stat rst", c, 5, 8'h60);
            rdc("id rst", c, 2, 8'h01);
        end
        rdc("unmapped", 0, 64, 0);
        bus(1, 0, 3, 8'h40);
        repeat (4) @(posedge ref_clk);
        chk("break line", 0, serial_out[0]);
        bus(1, 0, 3, 0);
        repeat (4) @(posedge ref_clk);
        chk("break release", 1, serial_out[0]);
        $display("break test done");
        for (int i = 0; i < 8; i++) begin
            ch = (i >> 2) & 1;
            dv = 1 + ((i >> 1) & 1);
            cfg = ($urandom & 8'h3C) | (i & 3);
            bus(1, ch, 3, 8'h80);
            bus(1, ch, 0, dv);
            d = $urandom & 255;
            bus(1, ch, 1, d);
            rdc("divisor high", ch, 1, d);
            bus(1, ch, 1, 0);
            rdc("divisor low", ch, 0, dv);
            bus(1, ch, 3, cfg);
            fmt_m[ch] = cfg;
            rdc("fmt", ch, 3, cfg);
            rdc("other fmt", 1 - ch, 3, fmt_m[1 - ch]);
            rdc("int en", ch, 1, 0);
            n = 5 + (i & 3);
            pn = (cfg >> 3) & 1;
            mask = (1 << n) - 1;
            d = $urandom & 255;
            p = cfg[5] ? !cfg[4] : (cfg[4] ? ^(d & mask) : !(^(d & mask)));
            nb = 2 + n + pn;
            fx = ((d & mask) << 1) | (pn * p << (n + 1)) | (1 << (n + 1 + pn));
            fork
                ufb_far_end_i.watch(ch, nb, 16 * dv, f, per);
                begin bus(1, ch, 0, d); bus(1, ch, 0, 0); end
            join
            chk("frame", fx, f);
            e = 16 * dv * (nb - 1) + (cfg[2] ? (n == 5 ? 24 : 32) : 16) * dv;
            // idle tick before next start
            chk("frame period", 1, per >= e && per <= e + dv);
            rdc("stat busy", ch, 5, 8'h20);
            e = 0;
            do begin bus(0, ch, 5, 0); e++; end while (q[6] !== 1'b1 && e < 400);
            chk("tx empty", 1, q[6]);
            bad = (i & 1) & pn;
            ufb_far_end_i.send(ch, fx ^ (bad << (n + 1)), nb, 16 * dv);
            repeat (4) @(posedge ref_clk);
            rdc("stat rx", ch, 5, 8'h61 | (bad << 2));
            rdc("rx data", ch, 0, d & mask);
            $display("format test %0d done", i);
        end
        finish_test();
    end
endmodule // test_uart_line_format_baud_gen
`default_nettype wire
